// ==== pm_event_consts.svh ====
// Offsets, field positions and reset values of the event block
`ifndef PM_EVENT_CONSTS_SVH
`define PM_EVENT_CONSTS_SVH

// ==========================================
// Register placement inside the event block
`define EVT_BLOCK_LEN 3'h4
`define EVT_STS_OFS 2'h0
`define EVT_EN_OFS 2'h2

// ==========================================
// Field positions, shared by status and enable except BIT_WAKE, which is status only
`define BIT_TMR 0
`define BIT_FWLOCK 5
`define BIT_PWRBTN 8
`define BIT_SLPBTN 9
`define BIT_ALARM 10
`define BIT_WAKE 15

// ==========================================
// Masks and reset values
`define EN_RESET 16'h0000
`define STS_RESET 16'h0000
`define EN_IMPL_MASK 16'h0721
`define STS_IMPL_MASK 16'h8721
`define RDATA_RESET 16'h0000

`endif

// ==== pm_event_pkg.sv ====
// Types shared by the event status and enable logic
package pm_event_pkg;

  // ==========================================
  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [1:0] addr;
    logic [1:0] be;
    logic [15:0] wdata;
  } io_req_t;

  // ==========================================
  // System power phase as seen by this block
  typedef enum logic [2:0] {
    PH_WORKING = 3'h1,
    PH_SLEEPING = 3'h2,
    PH_RESUMING = 3'h4
  } phase_t;

  // ==========================================
  // Whole state of the block
  typedef struct packed {
    logic [15:0] sts;
    logic [15:0] en;
    logic [15:0] rdata;
    logic alarm_q;
    logic pbtn_q;
    logic sbtn_q;
    logic msb_q;
    phase_t phase;
  } state_t;

endpackage

// ==== pm_event_block.sv ====
// Event status and enable registers with interrupt and wake steering
`timescale 1ns/1ns
`include "pm_event_consts.svh"

module pm_event_block (
  // Clock, reset, clock enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Register port
  input wire pm_event_pkg::io_req_t io_req,
  output logic [15:0] io_rdata,
  // Event sources
  input wire logic alarm_line,
  input wire logic power_button,
  input wire logic sleep_button,
  input wire logic counter_msb,
  input wire logic fw_lock_request,
  // System state
  input wire logic event_route_select,
  input wire logic deep_wake_capable,
  input wire logic sleep_entry,
  input wire logic sleep_is_s4,
  input wire logic resume_done,
  input wire logic cold_entry,
  // Interrupts and wake
  output logic control_interrupt,
  output logic management_interrupt,
  output logic irq,
  output logic resume_request
);

  // ==========================================
  // State
  pm_event_pkg::state_t st;
  pm_event_pkg::state_t next_st;

  logic [15:0] set_bits;
  logic [15:0] lane_mask;
  logic [15:0] wake_src;
  logic sts_wr;
  logic en_wr;
  logic sleeping;
  logic pending;
  logic wake_evt;
  logic alarm_wake_ok;

  // ==========================================
  // Decode of the register port
  // Each group answers only inside its own block window
  assign lane_mask = {{8{io_req.be[1]}}, {8{io_req.be[0]}}};
  assign sts_wr = io_req.wr && io_req.addr == `EVT_STS_OFS;
  assign en_wr = io_req.wr && io_req.addr == `EVT_EN_OFS;

  // ==========================================
  // Event detection
  assign sleeping = st.phase == pm_event_pkg::PH_SLEEPING;
  // A wake from S4 by the alarm needs the deep-wake capability
  assign alarm_wake_ok = !sleep_is_s4 || deep_wake_capable;

  always_comb begin
    set_bits = 16'h0000;
    set_bits[`BIT_TMR] = counter_msb != st.msb_q;
    set_bits[`BIT_FWLOCK] = fw_lock_request;
    set_bits[`BIT_PWRBTN] = power_button && !st.pbtn_q;
    set_bits[`BIT_SLPBTN] = sleep_button && !st.sbtn_q;
    set_bits[`BIT_ALARM] = alarm_line && !st.alarm_q;
  end

  // Wake sources are flags already set and allowed
  always_comb begin
    wake_src = 16'h0000;
    wake_src[`BIT_PWRBTN] = st.en[`BIT_PWRBTN];
    wake_src[`BIT_SLPBTN] = st.en[`BIT_SLPBTN];
    wake_src[`BIT_ALARM] = st.en[`BIT_ALARM] && alarm_wake_ok;
  end

  assign wake_evt = sleeping && |(st.sts & wake_src);

  // ==========================================
  // Next state
  always_comb begin
    next_st = st;
    next_st.alarm_q = alarm_line;
    next_st.pbtn_q = power_button;
    next_st.sbtn_q = sleep_button;
    next_st.msb_q = counter_msb;
    // Write one clears; a set in the same cycle still wins
    if (sts_wr) begin
      next_st.sts = st.sts & ~(io_req.wdata & lane_mask);
    end
    next_st.sts = next_st.sts | set_bits;
    if (wake_evt) begin
      next_st.sts[`BIT_WAKE] = 1'b1;
    end
    next_st.sts = next_st.sts & `STS_IMPL_MASK;
    if (en_wr) begin
      next_st.en = (st.en & ~lane_mask)
                 | (io_req.wdata & lane_mask & `EN_IMPL_MASK);
    end
    // Power-up from off states must start with nothing allowed
    if (cold_entry) begin
      next_st.en = `EN_RESET;
    end
    if (io_req.rd) begin
      case (io_req.addr)
        `EVT_STS_OFS: next_st.rdata = st.sts & `STS_IMPL_MASK;
        `EVT_EN_OFS: next_st.rdata = st.en & `EN_IMPL_MASK;
        default: next_st.rdata = `RDATA_RESET;
      endcase
    end
    case (st.phase)
      pm_event_pkg::PH_WORKING: begin
        if (sleep_entry) begin
          next_st.phase = pm_event_pkg::PH_SLEEPING;
        end
      end
      pm_event_pkg::PH_SLEEPING: begin
        if (st.sts[`BIT_WAKE]) begin
          next_st.phase = pm_event_pkg::PH_RESUMING;
        end
      end
      pm_event_pkg::PH_RESUMING: begin
        if (resume_done) begin
          next_st.phase = pm_event_pkg::PH_WORKING;
        end
      end
      default: next_st.phase = pm_event_pkg::PH_WORKING;
    endcase
  end

  // ==========================================
  // Registers
  always_ff @(posedge clk) begin
    if (rst) begin
      st.sts <= `STS_RESET;
      st.en <= `EN_RESET;
      st.rdata <= `RDATA_RESET;
      st.alarm_q <= 1'b0;
      st.pbtn_q <= 1'b0;
      st.sbtn_q <= 1'b0;
      st.msb_q <= 1'b0;
      st.phase <= pm_event_pkg::PH_WORKING;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // ==========================================
  // Outputs
  // Level request: stays up until the flags or their allow bits are cleared (software or cold_entry)
  assign pending = |(st.sts & st.en & `EN_IMPL_MASK);
  assign irq = pending;
  assign control_interrupt = pending && event_route_select;
  assign management_interrupt = pending && !event_route_select;
  assign resume_request = st.phase == pm_event_pkg::PH_RESUMING;
  assign io_rdata = st.rdata;

  // ==========================================
  // Checks
  sequence alarm_rise;
    ce && alarm_line && !st.alarm_q;
  endsequence

  sequence wake_seen;
    ce && sleeping && st.sts[`BIT_WAKE];
  endsequence

  a_alarm_flag_set: assert property (
    @(posedge clk) disable iff (rst)
    alarm_rise |=> st.sts[`BIT_ALARM])
    else $error("alarm flag not set after alarm rise");

  a_alarm_w1c_zero: assert property (
    @(posedge clk) disable iff (rst)
    ce && st.sts[`BIT_ALARM] && sts_wr && !io_req.wdata[`BIT_ALARM]
    |=> st.sts[`BIT_ALARM])
    else $error("writing zero cleared alarm flag");

  a_flag_one_clear: assert property (
    @(posedge clk) disable iff (rst)
    ce && sts_wr && io_req.be[1] && io_req.wdata[`BIT_WAKE] && !wake_evt
    |=> !st.sts[`BIT_WAKE])
    else $error("wake flag not cleared by writing one");

  a_reserved_zero: assert property (
    @(posedge clk) disable iff (rst)
    ce && io_req.rd |=> (st.rdata & ~`STS_IMPL_MASK) == 16'h0000
      && (st.rdata & ~`EN_IMPL_MASK & 16'h7FFF) == 16'h0000)
    else $error("reserved bits read nonzero");

  a_wake_resume: assert property (
    @(posedge clk) disable iff (rst)
    wake_seen |=> resume_request)
    else $error("wake flag did not start resume");

  a_wake_flag_set: assert property (
    @(posedge clk) disable iff (rst)
    ce && wake_evt |=> st.sts[`BIT_WAKE])
    else $error("enabled wake in sleep did not set wake flag");

  a_timer_gate: assert property (
    @(posedge clk) disable iff (rst)
    st.sts[`BIT_TMR] && st.en[`BIT_TMR] |-> irq)
    else $error("timer carry allowed but no interrupt");

  a_route_select: assert property (
    @(posedge clk) disable iff (rst)
    irq |-> (control_interrupt != management_interrupt)
      && (control_interrupt == event_route_select))
    else $error("interrupt routed to wrong output");

  a_button_regard: assert property (
    @(posedge clk) disable iff (rst)
    ce && power_button && !st.pbtn_q && !st.en[`BIT_PWRBTN]
    |=> st.sts[`BIT_PWRBTN])
    else $error("power button flag gated by allow bit");

  a_timer_toggle: assert property (
    @(posedge clk) disable iff (rst)
    ce && counter_msb != st.msb_q |=> st.sts[`BIT_TMR])
    else $error("counter top bit toggle missed");

  a_cold_clear: assert property (
    @(posedge clk) disable iff (rst)
    ce && cold_entry |=> st.en == 16'h0000)
    else $error("enables not cleared on cold entry");

  a_enable_reset: assert property (
    @(posedge clk)
    rst |=> st.en == 16'h0000 && irq == 1'b0)
    else $error("enable register not zero after reset");

  a_sleep_regard: assert property (
    @(posedge clk) disable iff (rst)
    ce && sleep_button && !st.sbtn_q && !st.en[`BIT_SLPBTN]
    |=> st.sts[`BIT_SLPBTN])
    else $error("sleep button flag gated by allow bit");

  a_fwlock_set: assert property (
    @(posedge clk) disable iff (rst)
    ce && fw_lock_request |=> st.sts[`BIT_FWLOCK])
    else $error("firmware request did not set its flag");

  a_low_lane_keep: assert property (
    @(posedge clk) disable iff (rst)
    ce && en_wr && !io_req.be[0] && !cold_entry
    |=> st.en[7:0] == $past(st.en[7:0]))
    else $error("unselected low lane of enable changed");

  a_high_lane_keep: assert property (
    @(posedge clk) disable iff (rst)
    ce && en_wr && !io_req.be[1] && !cold_entry
    |=> st.en[15:8] == $past(st.en[15:8]))
    else $error("unselected high lane of enable changed");

  // The alarm is the only wake source shut off here; the button wakes stay open
  a_deep_wake_block: assert property (
    @(posedge clk) disable iff (rst)
    ce && sleeping && sleep_is_s4 && !deep_wake_capable
      && !st.sts[`BIT_WAKE]
      && !(st.sts[`BIT_PWRBTN] && st.en[`BIT_PWRBTN])
      && !(st.sts[`BIT_SLPBTN] && st.en[`BIT_SLPBTN])
    |=> !st.sts[`BIT_WAKE])
    else $error("alarm woke deep sleep without capability");

  a_no_wake_awake: assert property (
    @(posedge clk) disable iff (rst)
    ce && !sleeping && !st.sts[`BIT_WAKE] |=> !st.sts[`BIT_WAKE])
    else $error("wake flag set outside sleep");

  a_resume_leave: assert property (
    @(posedge clk) disable iff (rst)
    ce && resume_request && resume_done |=> !resume_request)
    else $error("resume request held after resume done");

  a_alarm_event: assert property (
    @(posedge clk) disable iff (rst)
    st.sts[`BIT_ALARM] && st.en[`BIT_ALARM]
    |-> control_interrupt || management_interrupt)
    else $error("allowed alarm flag raised no event");

  a_unmapped_zero: assert property (
    @(posedge clk) disable iff (rst)
    ce && io_req.rd && io_req.addr[0] |=> io_rdata == `RDATA_RESET)
    else $error("unmapped offset read nonzero");

  // A low clock enable must hold every flip-flop
  a_freeze_hold: assert property (
    @(posedge clk) disable iff (rst)
    !ce |=> st == $past(st))
    else $error("state changed while clock enable low");

endmodule

// ==== pm_event_block_bench.sv ====
// Self-checking bench for the event status and enable block
`timescale 1ns/1ns
`include "pm_event_consts.svh"

module pm_event_block_bench;
  // ==========================================
  // Signals
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  pm_event_pkg::io_req_t io_req = '0;
  logic [15:0] io_rdata;
  logic alarm_line = 0, power_button = 0, sleep_button = 0;
  logic counter_msb = 0, fw_lock_request = 0, event_route_select = 0;
  logic deep_wake_capable = 0, sleep_entry = 0, sleep_is_s4 = 0;
  logic resume_done = 0, cold_entry = 0;
  logic control_interrupt, management_interrupt, irq, resume_request;
  int n_mismatch = 0;
  int cmp_count = 0;
  typedef struct packed {
    logic [1:0] be;
    logic [15:0] d;
    logic [15:0] exp;
  } row_t;
  row_t rows [6] = '{'{2'h3, 16'hFFFF, 16'h0721},
    '{2'h1, 16'h0000, 16'h0700}, '{2'h2, 16'h0000, 16'h0000},
    '{2'h1, 16'hFFFF, 16'h0021}, '{2'h2, 16'hFFFF, 16'h0721},
    '{2'h3, 16'h0000, 16'h0000}};
  int bits [5] = '{0, 5, 8, 9, 10};

  always #5 clk = ~clk;

  pm_event_block pm_event_block_i (.clk(clk), .rst(rst), .ce(ce),
    .io_req(io_req), .io_rdata(io_rdata), .alarm_line(alarm_line),
    .power_button(power_button), .sleep_button(sleep_button),
    .counter_msb(counter_msb), .fw_lock_request(fw_lock_request),
    .event_route_select(event_route_select),
    .deep_wake_capable(deep_wake_capable), .sleep_entry(sleep_entry),
    .sleep_is_s4(sleep_is_s4), .resume_done(resume_done),
    .cold_entry(cold_entry), .control_interrupt(control_interrupt),
    .management_interrupt(management_interrupt), .irq(irq),
    .resume_request(resume_request));

  // ==========================================
  // Helpers; inputs change only at the falling edge
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Idle cycle after each strobe so no signal is set twice in a step
  task automatic wr(input logic [1:0] a, input logic [1:0] be,
                    input logic [15:0] d);
    io_req = '{wr: 1'b1, rd: 1'b0, addr: a, be: be, wdata: d};
    tick(1);
    io_req = '0;
    tick(1);
  endtask

  task automatic rd(input logic [1:0] a, input string what,
                    input logic [15:0] exp);
    io_req = '{wr: 1'b0, rd: 1'b1, addr: a, be: 2'h3, wdata: 16'h0};
    tick(1);
    io_req = '0;
    chk(what, exp, io_rdata);
    tick(1);
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
    tick(2);
  endtask

  task automatic tally_and_finish();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ==========================================
  // Watchdog, far beyond the roughly 150 cycles the run needs
  initial begin
    #50000;
    n_mismatch++;
    tally_and_finish();
  end

  // ==========================================
  // Main sequence
  initial begin
    tick(2);
    rst = 1'b0;
    tick(1);
    rd(2'h2, "enable", 16'h0000);
    rd(2'h0, "status", 16'h0000);
    foreach (rows[i]) begin
      wr(2'h2, rows[i].be, rows[i].d);
      rd(2'h2, "enable", rows[i].exp);
    end
    wr(2'h1, 2'h3, 16'hFFFF);
    rd(2'h1, "unmapped", 16'h0000);
    rd(2'h3, "unmapped", 16'h0000);
    rd(2'h2, "enable", 16'h0000);
    // Flags set with every allow bit clear
    pulse(power_button);
    pulse(sleep_button);
    pulse(fw_lock_request);
    pulse(alarm_line);
    pulse(counter_msb);
    chk("irq", 16'h0, irq);
    rd(2'h0, "status", 16'h0721);
    wr(2'h0, 2'h3, 16'h0000);
    rd(2'h0, "status", 16'h0721);
    // Each of the five flags raises irq once its own allow bit is set
    foreach (bits[i]) begin
      wr(2'h2, 2'h3, 16'h0001 << bits[i]);
      chk("irq", 16'h1, irq);
    end
    event_route_select = 1'b1;
    tick(1);
    chk("ctl", 16'h1, control_interrupt);
    chk("mgmt", 16'h0, management_interrupt);
    event_route_select = 1'b0;
    tick(1);
    chk("ctl", 16'h0, control_interrupt);
    chk("mgmt", 16'h1, management_interrupt);
    wr(2'h0, 2'h1, 16'h0001);
    rd(2'h0, "status", 16'h0720);
    chk("irq", 16'h1, irq);
    wr(2'h0, 2'h3, 16'hFFFF);
    rd(2'h0, "status", 16'h0000);
    chk("irq", 16'h0, irq);
    // A flag event in the clearing cycle must win over the clear
    fw_lock_request = 1'b1;
    io_req = '{wr: 1'b1, rd: 1'b0, addr: 2'h0, be: 2'h3, wdata: 16'hFFFF};
    tick(1);
    fw_lock_request = 1'b0;
    io_req = '0;
    tick(1);
    rd(2'h0, "status", 16'h0020);
    wr(2'h0, 2'h3, 16'hFFFF);
    // Alarm wake from light sleep
    pulse(sleep_entry);
    pulse(alarm_line);
    tick(2);
    chk("resume", 16'h1, resume_request);
    rd(2'h0, "status", 16'h8400);
    pulse(resume_done);
    chk("resume", 16'h0, resume_request);
    wr(2'h0, 2'h3, 16'hFFFF);
    rd(2'h0, "status", 16'h0000);
    // Alarm in deep sleep wakes only when deep wake is allowed
    sleep_is_s4 = 1'b1;
    pulse(sleep_entry);
    pulse(alarm_line);
    tick(2);
    chk("resume", 16'h0, resume_request);
    rd(2'h0, "status", 16'h0400);
    wr(2'h0, 2'h3, 16'hFFFF);
    deep_wake_capable = 1'b1;
    pulse(alarm_line);
    tick(2);
    chk("resume", 16'h1, resume_request);
    rd(2'h0, "status", 16'h8400);
    pulse(resume_done);
    wr(2'h0, 2'h3, 16'hFFFF);
    // Frozen clock enable, then entry from an off state
    ce = 1'b0;
    wr(2'h2, 2'h3, 16'hFFFF);
    ce = 1'b1;
    rd(2'h2, "enable", 16'h0400);
    pulse(cold_entry);
    rd(2'h2, "enable", 16'h0000);
    // Enables are already clear when the route goes to control
    event_route_select = 1'b1;
    tick(1);
    chk("ctl", 16'h0, control_interrupt);
    // Reset in mid-run returns both registers to zero
    wr(2'h2, 2'h3, 16'hFFFF);
    pulse(fw_lock_request);
    chk("ctl", 16'h1, control_interrupt);
    pulse(rst);
    chk("irq", 16'h0, irq);
    rd(2'h2, "enable", 16'h0000);
    rd(2'h0, "status", 16'h0000);
    tally_and_finish();
  end
endmodule
